// ---- tsxe_consts.vh ----
// Constants for the test-skip / XOR execution block.
// Assumes inclusion by bare name from the design files of the block.
`ifndef TSXE_CONSTS_VH
`define TSXE_CONSTS_VH

// Opcode patterns (upper bits of the 16-bit instruction word)
`define TSXE_OP_TST_HI     7'h33
`define TSXE_OP_XLW_HI     8'h0A
`define TSXE_OP_XWF_HI     6'h06
`define TSXE_OP_ADDPTR_HI  8'hE8
`define TSXE_OP_SUBPTR_HI  8'hE9
`define TSXE_PTR_TWO_SEL   2'h3
// Two-word instruction prefixes checked when a skip lands on one
`define TSXE_OP_LONG_HI4   4'hE
`define TSXE_OP_LONG_CALL  7'h76
`define TSXE_OP_LONG_GOTO  8'hEF
`define TSXE_OP_LONG_LFSR  8'hEE
`define TSXE_OP_LONG_MOVSX 8'hEB
`define TSXE_OP_MOVFF_HI4  4'hC
// Indexed literal offset limit (95)
`define TSXE_ILO_LIMIT     8'h5F
// Access bank upper half starts here
`define TSXE_ACC_SPLIT     8'h60
`define TSXE_ACC_HI_BANK   4'hF
// Field positions
`define TSXE_A_BIT         8
`define TSXE_D_BIT         9
// Reset values
`define TSXE_W_RST         8'h00
`define TSXE_BSR_RST       4'h0
`define TSXE_PTR_RST       12'h000
// Q phase one-hot encodings
`define TSXE_Q1            4'h1
`define TSXE_Q2            4'h2
`define TSXE_Q3            4'h4
`define TSXE_Q4            4'h8

`endif

// ---- tsxe_addr_gen.v ----
// Effective file address generator for byte-oriented operations.
// Assumes pointer two and bank select come from the core, all synchronous.
`timescale 1ns/100ps
`default_nettype none
`include "tsxe_consts.vh"

module tsxe_addr_gen #(
    parameter AW = 12
) (
    // Instruction fields
    input  wire [7:0]    file_addr_i,
    input  wire          access_bit_i,
    input  wire          ext_en_i,
    // Base registers
    input  wire [3:0]    bank_select_i,
    input  wire [AW-1:0] ptr_two_i,
    // Result
    output reg  [AW-1:0] eff_addr_o,
    output reg           indexed_o
);

    // Bank choice, then indexed literal offset override
    always @* begin
        indexed_o = 1'b0;
        if (access_bit_i) begin
            eff_addr_o = {bank_select_i, file_addr_i};
        end else if (ext_en_i && (file_addr_i <= `TSXE_ILO_LIMIT)) begin
            // Offset from pointer two replaces direct access addressing
            eff_addr_o = ptr_two_i + {{(AW-8){1'b0}}, file_addr_i};
            indexed_o  = 1'b1;
        end else if (file_addr_i < `TSXE_ACC_SPLIT) begin
            eff_addr_o = {4'h0, file_addr_i};
        end else begin
            eff_addr_o = {`TSXE_ACC_HI_BANK, file_addr_i};
        end
    end

endmodule
`default_nettype wire

// ---- tsxe_core.v ----
// Decode and execution of test-skip-if-zero, XOR literal and XOR file.
// Assumes a synchronous file memory port answering reads in the same Q phase,
// and a fetch unit that presents instructions and honours the flush output.
`timescale 1ns/100ps
`default_nettype none
`include "tsxe_consts.vh"

module tsxe_core #(
    parameter AW = 12
) (
    // Clock and reset
    input  wire          clock_i,
    input  wire          rst_n_i,
    // Configuration
    input  wire          ext_set_config_bit_i,
    // Instruction fetch
    input  wire [15:0]   instr_i,
    input  wire          instr_valid_i,
    output wire          flush_o,
    output reg           return_o,
    // File memory port
    output wire [AW-1:0] file_addr_o,
    input  wire [7:0]    file_rdata_i,
    output reg  [7:0]    file_wdata_o,
    output reg           file_we_o,
    // Register access port
    input  wire [3:0]    addr_i,
    input  wire [7:0]    wdata_i,
    input  wire          wr_i,
    input  wire          rd_i,
    output reg  [7:0]    rdata_o,
    // Visible state
    output wire [3:0]    q_phase_o,
    output wire [7:0]    accum_o,
    output wire          flag_n_o,
    output wire          flag_z_o,
    output wire [AW-1:0] ptr_two_o,
    output wire          busy_o
);

    // Register offsets on the local port
    localparam [3:0] REG_ACCUM  = 4'h0;
    localparam [3:0] REG_STATUS = 4'h1;
    localparam [3:0] REG_BANK   = 4'h2;
    localparam [3:0] REG_PTR_LO = 4'h3;
    localparam [3:0] REG_PTR_HI = 4'h4;
    localparam [3:0] REG_CTRL   = 4'h5;
    localparam [3:0] REG_STATE  = 4'h6;
    localparam [3:0] REG_OTHER  = 4'h7;

    // Execution states, one-hot
    localparam [2:0] ST_EXEC  = 3'h1;
    localparam [2:0] ST_NOP1  = 3'h2;
    localparam [2:0] ST_NOP2  = 3'h4;

    reg [3:0]    q_reg;
    reg [2:0]    state_reg;
    reg [15:0]   ir_reg;
    reg          ir_valid_reg;
    reg [7:0]    accum_reg;
    reg          flag_n_reg;
    reg          flag_z_reg;
    reg [2:0]    other_flags_reg;
    reg [3:0]    bank_reg;
    reg [AW-1:0] ptr_two_reg;
    reg          ext_dis_reg;
    reg          skip_long_reg;
    reg [7:0]    opnd_reg;
    reg [7:0]    result_reg;

    wire         ext_en;
    wire [AW-1:0] eff_addr;
    wire         indexed;
    wire         is_tst;
    wire         is_xlw;
    wire         is_xwf;
    wire         is_addret;
    wire         is_subret;
    wire         is_long;
    wire         run_exec;

    // Configuration bit is on when unprogrammed; software can also force it off
    assign ext_en = ext_set_config_bit_i & ~ext_dis_reg;

    // Decode from the held instruction
    assign is_tst    = (ir_reg[15:9] == `TSXE_OP_TST_HI);
    assign is_xlw    = (ir_reg[15:8] == `TSXE_OP_XLW_HI);
    assign is_xwf    = (ir_reg[15:10] == `TSXE_OP_XWF_HI);
    assign is_addret = ext_en && (ir_reg[15:8] == `TSXE_OP_ADDPTR_HI)
                       && (ir_reg[7:6] == `TSXE_PTR_TWO_SEL);
    assign is_subret = ext_en && (ir_reg[15:8] == `TSXE_OP_SUBPTR_HI)
                       && (ir_reg[7:6] == `TSXE_PTR_TWO_SEL);

    // Two-word instructions sitting in the fetch slot
    assign is_long = (instr_i[15:9] == `TSXE_OP_LONG_CALL)
                     || (instr_i[15:8] == `TSXE_OP_LONG_GOTO)
                     || (instr_i[15:8] == `TSXE_OP_LONG_LFSR)
                     || (instr_i[15:12] == `TSXE_OP_MOVFF_HI4)
                     || (ext_en && instr_i[15:8] == `TSXE_OP_LONG_MOVSX);

    assign run_exec = (state_reg == ST_EXEC) && ir_valid_reg;

    // Effective address, shared by both file operations
    tsxe_addr_gen #(
        .AW (AW)
    ) u_addr (
        .file_addr_i   (ir_reg[7:0]),
        .access_bit_i  (ir_reg[`TSXE_A_BIT]),
        .ext_en_i      (ext_en),
        .bank_select_i (bank_reg),
        .ptr_two_i     (ptr_two_reg),
        .eff_addr_o    (eff_addr),
        .indexed_o     (indexed)
    );

    assign file_addr_o = eff_addr;
    assign q_phase_o   = q_reg;
    assign accum_o     = accum_reg;
    assign flag_n_o    = flag_n_reg;
    assign flag_z_o    = flag_z_reg;
    assign ptr_two_o   = ptr_two_reg;
    assign busy_o      = (state_reg != ST_EXEC);
    // Flush on Q4 of a taken skip drops the prefetched word
    assign flush_o     = run_exec && is_tst && (q_reg == `TSXE_Q4)
                         && (opnd_reg == 8'h00);

    // Q phase ring: Q1 decode, Q2 read, Q3 process, Q4 write
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_reg <= `TSXE_Q1;
        end else begin
            q_reg <= {q_reg[2:0], q_reg[3]};
        end
    end

    // Instruction register and skip sequencing
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg     <= ST_EXEC;
            ir_reg        <= 16'h0000;
            ir_valid_reg  <= 1'b0;
            skip_long_reg <= 1'b0;
        end else if (q_reg == `TSXE_Q4) begin
            case (state_reg)
                ST_EXEC: begin
                    if (flush_o) begin
                        // Discarded word runs as a NOP cycle
                        state_reg     <= ST_NOP1;
                        skip_long_reg <= is_long;
                        ir_valid_reg  <= 1'b0;
                    end else begin
                        ir_reg       <= instr_i;
                        ir_valid_reg <= instr_valid_i;
                    end
                end
                ST_NOP1: begin
                    if (skip_long_reg) begin
                        state_reg <= ST_NOP2;
                    end else begin
                        state_reg    <= ST_EXEC;
                        ir_reg       <= instr_i;
                        ir_valid_reg <= instr_valid_i;
                    end
                end
                ST_NOP2: begin
                    // Second word of the skipped instruction is also dropped
                    state_reg     <= ST_EXEC;
                    skip_long_reg <= 1'b0;
                    ir_reg        <= instr_i;
                    ir_valid_reg  <= instr_valid_i;
                end
                default: begin
                    state_reg    <= ST_EXEC;
                    ir_valid_reg <= 1'b0;
                end
            endcase
        end
    end

    // Datapath: read in Q2, process in Q3, write in Q4
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opnd_reg     <= 8'h00;
            result_reg   <= 8'h00;
            accum_reg    <= `TSXE_W_RST;
            flag_n_reg   <= 1'b0;
            flag_z_reg   <= 1'b0;
            file_wdata_o <= 8'h00;
            file_we_o    <= 1'b0;
            return_o     <= 1'b0;
            ptr_two_reg  <= `TSXE_PTR_RST;
        end else begin
            file_we_o <= 1'b0;
            return_o  <= 1'b0;
            if (run_exec && q_reg == `TSXE_Q2) begin
                // Literal for XOR literal, file value for the others
                opnd_reg <= is_xlw ? ir_reg[7:0] : file_rdata_i;
            end
            if (run_exec && q_reg == `TSXE_Q3) begin
                result_reg <= accum_reg ^ opnd_reg;
                if (is_xwf && ir_reg[`TSXE_D_BIT]) begin
                    // Data lands on Q4 together with the write enable
                    file_wdata_o <= accum_reg ^ opnd_reg;
                    file_we_o    <= 1'b1;
                end
            end
            if (run_exec && q_reg == `TSXE_Q4) begin
                if (is_xlw || (is_xwf && !ir_reg[`TSXE_D_BIT])) begin
                    accum_reg <= result_reg;
                end
                if (is_xlw || is_xwf) begin
                    // Test instruction leaves every flag alone
                    flag_n_reg <= result_reg[7];
                    flag_z_reg <= (result_reg == 8'h00);
                end
                if (is_addret) begin
                    ptr_two_reg <= ptr_two_reg + {{(AW-6){1'b0}}, ir_reg[5:0]};
                    return_o    <= 1'b1;
                end else if (is_subret) begin
                    ptr_two_reg <= ptr_two_reg - {{(AW-6){1'b0}}, ir_reg[5:0]};
                    return_o    <= 1'b1;
                end
            end
            // Software access to W, pointer two and the N and Z flags at any time; it wins over the datapath writes
            if (wr_i && addr_i == REG_ACCUM) begin
                accum_reg <= wdata_i;
            end else if (wr_i && addr_i == REG_PTR_LO) begin
                ptr_two_reg[7:0] <= wdata_i;
            end else if (wr_i && addr_i == REG_PTR_HI) begin
                ptr_two_reg[AW-1:8] <= wdata_i[AW-9:0];
            end else if (wr_i && addr_i == REG_STATUS) begin
                flag_n_reg <= wdata_i[4];
                flag_z_reg <= wdata_i[2];
            end
        end
    end

    // Software-owned control registers
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bank_reg        <= `TSXE_BSR_RST;
            ext_dis_reg     <= 1'b0;
            other_flags_reg <= 3'h0;
        end else if (wr_i) begin
            if (addr_i == REG_BANK) begin
                bank_reg <= wdata_i[3:0];
            end else if (addr_i == REG_CTRL) begin
                ext_dis_reg <= wdata_i[0];
            end else if (addr_i == REG_STATUS) begin
                // Carry, digit carry, overflow are never touched by the XORs
                other_flags_reg <= {wdata_i[3], wdata_i[1:0]};
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads as zero
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            if (addr_i == REG_ACCUM) begin
                rdata_o <= accum_reg;
            end else if (addr_i == REG_STATUS) begin
                rdata_o <= {3'h0, flag_n_reg, other_flags_reg[2], flag_z_reg, other_flags_reg[1:0]};
            end else if (addr_i == REG_BANK) begin
                rdata_o <= {4'h0, bank_reg};
            end else if (addr_i == REG_PTR_LO) begin
                rdata_o <= ptr_two_reg[7:0];
            end else if (addr_i == REG_PTR_HI) begin
                rdata_o <= {{(16-AW){1'b0}}, ptr_two_reg[AW-1:8]};
            end else if (addr_i == REG_CTRL) begin
                rdata_o <= {6'h00, ext_en, ext_dis_reg};
            end else if (addr_i == REG_STATE) begin
                rdata_o <= {2'h0, indexed, ir_valid_reg, skip_long_reg, state_reg};
            end else begin
                rdata_o <= 8'h00;
            end
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// ---- tsxe_core_properties.sv ----
// Port-level checker for the test-skip / XOR execution core.
// Assumes one clock, async active-low reset, words taken at the end of Q4.
`timescale 1ns/100ps
`default_nettype none
module tsxe_core_chk (
    // Watched ports
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic [15:0] instr_i,
    input wire logic        instr_valid_i,
    input wire logic        flush_o,
    input wire logic        return_o,
    input wire logic [7:0]  file_rdata_i,
    input wire logic [7:0]  file_wdata_o,
    input wire logic        file_we_o,
    input wire logic [3:0]  q_phase_o,
    input wire logic [7:0]  accum_o,
    input wire logic        flag_n_o,
    input wire logic        flag_z_o,
    input wire logic        busy_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Word taken outside skips; NOP-cycle loads are left out to stay safe
    wire ld = q_phase_o == 4'h8 && instr_valid_i && !flush_o && !busy_o;

    chk_q_order:
        assert property (q_phase_o == 4'h1 |=> q_phase_o == 4'h2 ##1 q_phase_o == 4'h4 ##1 q_phase_o == 4'h8)
        else $error("Q phases out of order");
    chk_flush_q4:
        assert property (flush_o |-> q_phase_o == 4'h8)
        else $error("Flush outside Q4");
    chk_flush_nop:
        assert property (flush_o |=> busy_o [*4])
        else $error("No NOP cycle after flush");
    chk_skip_bound:
        assert property (flush_o |-> ##9 !busy_o)
        else $error("Skip longer than three cycles");
    chk_tst_flags:
        assert property (ld && instr_i[15:9] == 7'h33 |-> ##5 $stable({flag_n_o, flag_z_o}))
        else $error("Test changed flags");
    chk_xlw_math:
        assert property (ld && instr_i[15:8] == 8'h0A |-> ##5 accum_o == ($past(accum_o, 2) ^ $past(instr_i[7:0], 5))
            && flag_n_o == accum_o[7] && flag_z_o == (accum_o == 8'h00))
        else $error("Literal XOR result wrong");
    chk_xwf_write:
        assert property (ld && instr_i[15:9] == 7'h0D |-> ##4 file_we_o
            && file_wdata_o == (accum_o ^ $past(file_rdata_i, 2)))
        else $error("File XOR write wrong");
    chk_xwf_to_w:
        assert property (ld && instr_i[15:9] == 7'h0C |-> ##4 !file_we_o
            ##1 accum_o == ($past(accum_o, 2) ^ $past(file_rdata_i, 3)))
        else $error("File XOR into W wrong");
    chk_return_src:
        assert property ($rose(return_o) |-> $past(instr_i[15:9], 5) == 7'h74 && $past(instr_i[7:6], 5) == 2'b11)
        else $error("Return without pointer-two op");

    // Main scenarios reached
    cover property (flush_o ##5 busy_o);
    cover property (ld && instr_i[15:8] == 8'h0A);
    cover property ($rose(return_o));
endmodule

bind tsxe_core tsxe_core_chk u_chk (
    .clock_i       (clock_i),
    .rst_n_i       (rst_n_i),
    .instr_i       (instr_i),
    .instr_valid_i (instr_valid_i),
    .flush_o       (flush_o),
    .return_o      (return_o),
    .file_rdata_i  (file_rdata_i),
    .file_wdata_o  (file_wdata_o),
    .file_we_o     (file_we_o),
    .q_phase_o     (q_phase_o),
    .accum_o       (accum_o),
    .flag_n_o      (flag_n_o),
    .flag_z_o      (flag_z_o),
    .busy_o        (busy_o)
);
`default_nettype wire

// ---- tb_cpu_test_skip_xor_exec.sv ----
// Self-checking bench for the test-skip / XOR execution core.
// Drives fetch, file memory and register port itself; expectations go through a note queue.
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_test_skip_xor_exec;
    typedef struct {int due; int sel; logic [11:0] a; logic [11:0] x;} tsxe_note_t;
    // Design inputs
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        ext_set_config_bit_i = 1'b1;
    logic [15:0] instr_i = 16'h0000;
    logic        instr_valid_i = 1'b0;
    logic [7:0]  file_rdata_i = 8'h00;
    logic [3:0]  addr_i = 4'h0;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    // Design outputs
    logic        flush_o, return_o, file_we_o, flag_n_o, flag_z_o, busy_o;
    logic [11:0] file_addr_o, ptr_two_o;
    logic [7:0]  file_wdata_o, rdata_o, accum_o;
    logic [3:0]  q_phase_o;
    // Bench state and reference values
    logic [7:0]  mem [0:4095];
    logic [7:0]  w_m = 8'h00;
    logic [1:0]  fl_m = 2'b00;
    logic [11:0] ptr_m = 12'h000;
    tsxe_note_t  q[$];
    tsxe_note_t  n;
    int          ncyc = 0;
    int          miscompares = 0;
    int          check_count = 0;

    tsxe_core #(.AW(12)) dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .ext_set_config_bit_i(ext_set_config_bit_i),
        .instr_i(instr_i), .instr_valid_i(instr_valid_i), .flush_o(flush_o), .return_o(return_o),
        .file_addr_o(file_addr_o), .file_rdata_i(file_rdata_i), .file_wdata_o(file_wdata_o),
        .file_we_o(file_we_o), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .q_phase_o(q_phase_o), .accum_o(accum_o), .flag_n_o(flag_n_o),
        .flag_z_o(flag_z_o), .ptr_two_o(ptr_two_o), .busy_o(busy_o)
    );

    // 25 MHz clock
    initial forever #20 clock_i = ~clock_i;

    // File memory: one clock read latency, written on the Q4 strobe
    always @(posedge clock_i) begin
        file_rdata_i <= mem[file_addr_o];
        if (file_we_o) mem[file_addr_o] <= file_wdata_o;
    end

    task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic note(input int d, input int s, input logic [11:0] a, input logic [11:0] x);
        q.push_back('{ncyc + d, s, a, x});
    endtask
    // One word per Q4 slot, dropped after the taking edge so it is not reloaded
    task automatic slot(input logic [15:0] w);
        do @(posedge clock_i); while (q_phase_o !== 4'h4);
        instr_i       <= w;
        instr_valid_i <= 1'b1;
        @(posedge clock_i);
        instr_valid_i <= 1'b0;
    endtask
    task automatic xlw(input logic [7:0] k);
        w_m ^= k;
        fl_m = {w_m[7], w_m == 8'h00};
        slot({8'h0A, k});
        note(5, 0, 0, 12'(w_m));
        note(5, 1, 0, 12'(fl_m));
    endtask
    task automatic xwf(input logic d, input logic a, input logic [7:0] f, input logic [11:0] ea, input logic [7:0] fv);
        logic [7:0] r;
        r = w_m ^ fv;
        mem[ea] = fv;
        fl_m = {r[7], r == 8'h00};
        if (!d) w_m = r;
        slot({6'h06, d, a, f});
        note(5, d ? 2 : 0, ea, 12'(r));
        note(5, 1, 0, 12'(fl_m));
    endtask
    // A zero operand costs a discarded word, a two-word victim costs its second word too
    task automatic tst(input logic a, input logic [7:0] f, input logic [11:0] ea, input logic [7:0] fv,
                       input logic lng, input logic [15:0] v);
        mem[ea] = fv;
        slot({7'h33, a, f});
        note(5, 1, 0, 12'(fl_m));
        note(6, 3, 0, 12'(fv == 8'h00));
        if (fv == 8'h00) begin
            // Only a two-word victim keeps the core busy into a third cycle
            note(10, 3, 0, 12'(lng));
            slot(v);
            if (lng) slot(16'hF0FF);
        end
    endtask
    task automatic pret(input logic s, input logic [5:0] k);
        ptr_m = s ? ptr_m - 12'(k) : ptr_m + 12'(k);
        slot({7'h74, s, 2'b11, k});
        note(5, 5, 0, ptr_m);
        note(5, 6, 0, 12'h001);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] x);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        note(2, 4, 0, 12'(x));
        @(posedge clock_i);
        rd_i <= 1'b0;
    endtask
    task automatic idle();
        repeat (12) @(posedge clock_i);
    endtask
    task automatic done(input string s);
        $display("test done: %s", s);
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Take each note off the queue when its edge comes round
    initial begin
        forever begin
            @(posedge clock_i);
            #1 ncyc++;
            while (q.size() > 0 && q[0].due <= ncyc) begin
                n = q.pop_front();
                case (n.sel)
                    0: chk("accum", 12'(accum_o), n.x);
                    1: chk("flags", 12'({flag_n_o, flag_z_o}), n.x);
                    2: chk("file", 12'(mem[n.a]), n.x);
                    3: chk("busy", 12'(busy_o), n.x);
                    4: chk("rdata", 12'(rdata_o), n.x);
                    5: chk("ptr", ptr_two_o, n.x);
                    default: chk("return", 12'(return_o), n.x);
                endcase
            end
        end
    end

    // Watchdog: the sequence needs well under 2000 clocks
    initial begin
        #400000;
        miscompares++;
        summarize();
    end

    initial begin
        int i;
        void'($urandom(32'hAA4B2A9B));
        for (i = 0; i < 4096; i++) mem[i] = 8'h00;
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1'b1;
        // Literal XOR, with OV, DC and C preset so their survival shows
        wr(4'h0, 8'hB5);
        wr(4'h1, 8'h0B);
        w_m = 8'hB5;
        xlw(8'hAF);
        idle();
        rd(4'h1, {3'b000, fl_m[1], 1'b1, fl_m[0], 2'b11});
        for (i = 0; i < 8; i++) xlw(8'($urandom));
        xlw(w_m);
        done("literal xor");
        // File XOR through bank, access bank and indexed addressing
        wr(4'h2, 8'h03);
        wr(4'h3, 8'h40);
        wr(4'h4, 8'h02);
        wr(4'h0, 8'hB5);
        ptr_m = 12'h240;
        w_m = 8'hB5;
        xwf(1, 1, 8'h25, 12'h325, 8'hAF);
        xwf(0, 1, 8'h80, 12'h380, 8'($urandom));
        xwf(1, 0, 8'h5F, 12'h29F, 8'($urandom));
        xwf(0, 0, 8'h60, 12'hF60, 8'($urandom));
        xwf(1, 0, 8'h00, 12'h240, 8'($urandom));
        idle();
        ext_set_config_bit_i <= 1'b0;
        rd(4'h5, 8'h00);
        xwf(1, 0, 8'h10, 12'h010, 8'($urandom));
        idle();
        ext_set_config_bit_i <= 1'b1;
        wr(4'h5, 8'h01);
        rd(4'h5, 8'h01);
        xwf(0, 0, 8'h20, 12'h020, 8'($urandom));
        idle();
        wr(4'h5, 8'h00);
        rd(4'h5, 8'h02);
        done("file xor");
        // Skip not taken, taken over one word, taken over two words
        tst(1, 8'h44, 12'h344, 8'h5A, 0, 16'h0AFF);
        tst(0, 8'h61, 12'hF61, 8'h00, 0, 16'h0AFF);
        xlw(8'h3C);
        tst(1, 8'h12, 12'h312, 8'h00, 1, 16'hEF00);
        // Indexed test, then every other two-word prefix as the victim
        tst(0, 8'h08, 12'h248, 8'h00, 1, 16'hC123);
        tst(1, 8'h13, 12'h313, 8'h00, 1, 16'hEC05);
        tst(1, 8'h14, 12'h314, 8'h00, 1, 16'hEE10);
        tst(1, 8'h15, 12'h315, 8'h00, 1, 16'hEB00);
        xlw(8'hC3);
        done("skip");
        pret(0, 6'h05);
        pret(1, 6'h3F);
        idle();
        rd(4'hF, 8'h00);
        rd(4'h3, ptr_m[7:0]);
        // Idle core: no indexed access, no valid word, no pending skip, executing state
        rd(4'h6, 8'h01);
        done("pointer");
        idle();
        summarize();
    end
endmodule
`default_nettype wire
